// ==== cpu_alu_branch_exec.sv ====
// Overview of operation
// - Add registers, optionally with carry; write sum, update Z C N V H; one cycle.
// - Add constant to 16-bit register pair; update Z C N V S; two cycles.
// - Subtract constant from 16-bit register pair; update Z C N V S; two cycles.
// - Subtract register or constant, optionally borrow; write, update Z C N V H; one cycle.
// - AND, OR, XOR with register or constant; write, update Z N V; one cycle.
// - Set-bits ORs a constant mask into the register; Z N V; one cycle.
// - Clear-bits ANDs with 0xFF minus mask; Z N V; one cycle.
// - Test ANDs register with itself to set Z N V; one cycle.
// - Integer multiplies write 16-bit product to pair one:zero; Z C; two cycles.
// - Fractional multiplies shift product left one first; Z C; two cycles.
// - Indirect jump loads PC from Z pointer; flags kept; two cycles.
// - Relative call pushes return, PC becomes PC plus offset plus one; three cycles.
// - Indirect call pushes return, PC loads Z pointer; three cycles.
// - Direct call pushes return, PC loads absolute target; four cycles.
// - Compare-skip on equal advances PC by two or three; 1, 2 or 3 cycles.
// - Compares only update Z N V C H; register untouched; one cycle.
// - Register bit skips on bit clear or set; 1, 2 or 3 cycles.
// - I/O bit skips on bit clear or set; 1, 2 or 3 cycles.
// - Flag branches go to PC plus offset plus one; 1 untaken, 2 taken.
// - Signed GE branches on N xor V zero, LT on one; 1 or 2 cycles.
// - Same-or-higher branches on carry clear, lower on carry set; 1 or 2 cycles.
`include "exec_defs.svh"

module cpu_alu_branch_exec (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic issue_valid,
    input wire exec_pkg::issue_type issue,
    output logic issue_ready,
    output exec_pkg::wr_type wr,
    output exec_pkg::push_type push,
    output logic [15:0] pc,
    output logic [7:0] status_flags
);
    import exec_pkg::*;

    // ****************************************
    // Decode helpers
    // ****************************************
    function automatic logic [7:0] flag_mask(input op_type op);
        case (op)
            OP_ADD, OP_ADD_CARRY, OP_SUB, OP_SUB_BORROW, OP_COMPARE, OP_COMPARE_CARRY: begin
                flag_mask = `MASK_ARITH;
            end
            OP_ADD_WORD, OP_SUB_WORD: begin
                flag_mask = `MASK_WORD;
            end
            OP_AND, OP_OR, OP_XOR, OP_SET_BITS, OP_CLEAR_BITS, OP_TEST: begin
                flag_mask = `MASK_LOGIC;
            end
            OP_MUL, OP_MUL_SIGNED, OP_MUL_MIXED, OP_FRACTIONAL_MULTIPLY, OP_FRACTIONAL_MULTIPLY_SIGNED, OP_FRACTIONAL_MULTIPLY_MIXED: begin
                flag_mask = `MASK_MUL;
            end
            default: begin
                flag_mask = `MASK_NONE;
            end
        endcase
    endfunction

    function automatic logic [2:0] base_cycles(input op_type op);
        case (op)
            OP_ADD_WORD, OP_SUB_WORD, OP_MUL, OP_MUL_SIGNED, OP_MUL_MIXED,
            OP_FRACTIONAL_MULTIPLY, OP_FRACTIONAL_MULTIPLY_SIGNED, OP_FRACTIONAL_MULTIPLY_MIXED, OP_JUMP_INDIRECT: begin
                base_cycles = `CYC_TWO;
            end
            OP_CALL_RELATIVE, OP_CALL_INDIRECT: begin
                base_cycles = `CYC_THREE;
            end
            OP_CALL_DIRECT: begin
                base_cycles = `CYC_FOUR;
            end
            default: begin
                base_cycles = `CYC_ONE;
            end
        endcase
    endfunction

    state_type s_q;
    state_type s_d;
    alu_out_type alu_out;
    logic accept;
    logic skip;
    logic take;
    logic [2:0] cycles;
    logic [7:0] mask;
    logic [15:0] rel_target;

    exec_alu u_alu (
        .iss(issue),
        .flags_in(s_q.flags),
        .alu_out(alu_out)
    );

    // Ready is combinational so a one-cycle instruction can follow back to back
    assign issue_ready = (s_q.phase == PH_READY);
    assign accept = issue_valid & issue_ready;
    assign rel_target = 16'(s_q.pc + {{4{issue.offset[11]}}, issue.offset} + 16'h0001);

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        s_d = s_q;
        s_d.wr.en = 1'b0;
        s_d.push.en = 1'b0;
        skip = 1'b0;
        take = 1'b0;
        cycles = `CYC_ONE;
        mask = flag_mask(issue.op);
        if (s_q.phase == PH_BUSY) begin
            s_d.busy = 3'(s_q.busy - 3'h1);
            if (s_q.busy == 3'h1) begin
                s_d.phase = PH_READY;
            end
        end else if (accept) begin
            case (issue.op)
                OP_SKIP_EQUAL: skip = (issue.rd_val[7:0] == issue.rr_val);
                OP_SKIP_REG_CLEAR: skip = ~issue.rr_val[issue.bit_sel];
                OP_SKIP_REG_SET: skip = issue.rr_val[issue.bit_sel];
                OP_SKIP_IO_CLEAR: skip = ~issue.io_bit;
                OP_SKIP_IO_SET: skip = issue.io_bit;
                OP_BRANCH_SET: take = s_q.flags[issue.bit_sel];
                OP_BRANCH_CLEAR: take = ~s_q.flags[issue.bit_sel];
                OP_BRANCH_GE: take = ~(s_q.flags[`FLAG_N] ^ s_q.flags[`FLAG_V]);
                OP_BRANCH_LT: take = s_q.flags[`FLAG_N] ^ s_q.flags[`FLAG_V];
                OP_BRANCH_SH: take = ~s_q.flags[`FLAG_C];
                OP_BRANCH_LO: take = s_q.flags[`FLAG_C];
                default: take = 1'b0;
            endcase
            // only the class's flag group changes
            s_d.flags = (alu_out.flags & mask) | (s_q.flags & ~mask);
            s_d.pc = 16'(s_q.pc + 16'h0001);
            case (issue.op)
                OP_ADD, OP_ADD_CARRY, OP_SUB, OP_SUB_BORROW, OP_AND, OP_OR, OP_XOR,
                OP_SET_BITS, OP_CLEAR_BITS, OP_TEST: begin
                    s_d.wr = '{en: 1'b1, pair: 1'b0, addr: issue.rd_addr, data: alu_out.res};
                end
                OP_ADD_WORD, OP_SUB_WORD: begin
                    s_d.wr = '{en: 1'b1, pair: 1'b1, addr: issue.rd_addr, data: alu_out.res};
                end
                OP_MUL, OP_MUL_SIGNED, OP_MUL_MIXED, OP_FRACTIONAL_MULTIPLY, OP_FRACTIONAL_MULTIPLY_SIGNED, OP_FRACTIONAL_MULTIPLY_MIXED: begin
                    s_d.wr = '{en: 1'b1, pair: 1'b1, addr: `PRODUCT_PAIR_ADDR, data: alu_out.res};
                end
                OP_JUMP_INDIRECT: begin
                    s_d.pc = issue.z_ptr;
                end
                OP_CALL_RELATIVE: begin
                    s_d.push = '{en: 1'b1, addr: 16'(s_q.pc + 16'h0001)};
                    s_d.pc = rel_target;
                end
                OP_CALL_INDIRECT: begin
                    s_d.push = '{en: 1'b1, addr: 16'(s_q.pc + 16'h0001)};
                    s_d.pc = issue.z_ptr;
                end
                OP_CALL_DIRECT: begin
                    // two-word call returns past its operand word
                    s_d.push = '{en: 1'b1, addr: 16'(s_q.pc + 16'h0002)};
                    s_d.pc = issue.call_target;
                end
                default: begin
                    s_d.wr.en = 1'b0;
                end
            endcase
            cycles = base_cycles(issue.op);
            if (skip) begin
                // skip length follows the skipped word count
                s_d.pc = 16'(s_q.pc + (issue.next_two_words ? 16'h0003 : 16'h0002));
                cycles = issue.next_two_words ? `CYC_THREE : `CYC_TWO;
            end
            if (take) begin
                // taken branch costs one extra cycle
                s_d.pc = rel_target;
                cycles = `CYC_TWO;
            end
            if (cycles != `CYC_ONE) begin
                s_d.phase = PH_BUSY;
                s_d.busy = 3'(cycles - 3'h1);
            end
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            s_q <= '{phase: PH_READY, busy: 3'h0, pc: `PC_RESET, flags: `FLAGS_RESET,
                     wr: '0, push: '0};
        end else begin
            s_q <= s_d;
        end
    end

    assign wr = s_q.wr;
    assign push = s_q.push;
    assign pc = s_q.pc;
    assign status_flags = s_q.flags;

    // ****************************************
    // Checks
    // ****************************************
    a_add_single_cycle: assert property (
        @(posedge core_clk) disable iff (!resetn)
        accept && issue.op == OP_ADD |=> issue_ready && wr.en && !wr.pair)
        else $error("add did not finish in one cycle");

    a_word_add_cycles: assert property (
        @(posedge core_clk) disable iff (!resetn)
        accept && issue.op == OP_ADD_WORD |=> !issue_ready && wr.pair ##1 issue_ready)
        else $error("word add did not take two cycles");

    a_word_sub_value: assert property (
        @(posedge core_clk) disable iff (!resetn)
        accept && issue.op == OP_SUB_WORD
        |=> wr.data == 16'($past(issue.rd_val) - {8'h00, $past(issue.imm)}))
        else $error("word subtract result wrong");

    a_logic_clears_v: assert property (
        @(posedge core_clk) disable iff (!resetn)
        accept && issue.op == OP_XOR |=> !status_flags[`FLAG_V] && $stable(status_flags[`FLAG_C]))
        else $error("logic op flag handling wrong");

    a_clear_bits_value: assert property (
        @(posedge core_clk) disable iff (!resetn)
        accept && issue.op == OP_CLEAR_BITS
        |=> wr.data[7:0] == ($past(issue.rd_val[7:0]) & ~$past(issue.imm)))
        else $error("clear bits result wrong");

    a_mul_pair_zero: assert property (
        @(posedge core_clk) disable iff (!resetn)
        accept && issue.op == OP_MUL |=> wr.en && wr.addr == 5'h00 && !issue_ready ##1 issue_ready)
        else $error("multiply destination or timing wrong");

    a_indirect_jump_target: assert property (
        @(posedge core_clk) disable iff (!resetn)
        accept && issue.op == OP_JUMP_INDIRECT |=> pc == $past(issue.z_ptr) && $stable(status_flags))
        else $error("indirect jump target wrong");

    a_call_timing: assert property (
        @(posedge core_clk) disable iff (!resetn)
        accept && issue.op == OP_CALL_DIRECT |=> push.en && !issue_ready ##1 !issue_ready [*2] ##1 issue_ready)
        else $error("direct call timing wrong");

    a_compare_no_write: assert property (
        @(posedge core_clk) disable iff (!resetn)
        accept && (issue.op == OP_COMPARE || issue.op == OP_COMPARE_CARRY) |=> !wr.en && issue_ready)
        else $error("compare wrote a register");

    a_skip_distance: assert property (
        @(posedge core_clk) disable iff (!resetn)
        accept && issue.op == OP_SKIP_EQUAL && issue.rd_val[7:0] == issue.rr_val && issue.next_two_words
        |=> pc == 16'($past(pc) + 16'h0003) ##2 issue_ready)
        else $error("skip distance or time wrong");

    a_branch_ge_taken: assert property (
        @(posedge core_clk) disable iff (!resetn)
        accept && issue.op == OP_BRANCH_GE && status_flags[`FLAG_N] == status_flags[`FLAG_V]
        |=> !issue_ready ##1 issue_ready)
        else $error("signed branch not taken");

    a_branch_keeps_flags: assert property (
        @(posedge core_clk) disable iff (!resetn)
        accept && issue.op == OP_BRANCH_LO |=> $stable(status_flags))
        else $error("branch changed flags");

    a_indirect_call_push: assert property (
        @(posedge core_clk) disable iff (!resetn)
        accept && issue.op == OP_CALL_INDIRECT
        |=> push.en && push.addr == 16'($past(pc) + 16'h0001)
            && pc == $past(issue.z_ptr))
        else $error("bad indirect call");

    a_fractional_multiply_shift: assert property (
        @(posedge core_clk) disable iff (!resetn)
        accept && issue.op == OP_FRACTIONAL_MULTIPLY && !issue.use_imm
        |=> wr.addr == 5'h00
            && wr.data == 16'(({8'h00, $past(issue.rd_val[7:0])} * {8'h00, $past(issue.rr_val)}) << 1))
        else $error("bad fraction product");

    a_branch_lo_taken: assert property (
        @(posedge core_clk) disable iff (!resetn)
        accept && issue.op == OP_BRANCH_LO && status_flags[`FLAG_C]
        |=> !issue_ready ##1 issue_ready)
        else $error("bad lower branch");

    a_reg_skip_clear: assert property (
        @(posedge core_clk) disable iff (!resetn)
        accept && issue.op == OP_SKIP_REG_CLEAR && !issue.rr_val[issue.bit_sel] && !issue.next_two_words
        |=> pc == 16'($past(pc) + 16'h0002) ##1 issue_ready)
        else $error("bad register skip");

endmodule

// ==== exec_alu.sv ====
`include "exec_defs.svh"

module exec_alu (
    input wire exec_pkg::issue_type iss,
    input wire logic [7:0] flags_in,
    output exec_pkg::alu_out_type alu_out
);
    import exec_pkg::*;

    logic [7:0] a;
    logic [7:0] b;
    logic cin;
    logic [8:0] sum;
    logic [7:0] r;
    logic [16:0] wsum;
    logic signed [15:0] ma;
    logic signed [15:0] mb;
    logic [15:0] prod;
    logic is_sub;
    logic keep_z;

    always_comb begin
        a = iss.rd_val[7:0];
        b = iss.use_imm ? iss.imm : iss.rr_val;
        cin = flags_in[`FLAG_C];
        is_sub = 1'b0;
        keep_z = 1'b0;
        sum = 9'h000;
        wsum = 17'h0_0000;
        ma = 16'h0000;
        mb = 16'h0000;
        alu_out.res = 16'h0000;
        alu_out.flags = flags_in;
        case (iss.op)
            OP_ADD, OP_ADD_CARRY: begin
                sum = {1'b0, a} + {1'b0, b} + {8'h00, (iss.op == OP_ADD_CARRY) & cin};
            end
            OP_SUB, OP_COMPARE: begin
                is_sub = 1'b1;
                sum = {1'b0, a} - {1'b0, b};
            end
            OP_SUB_BORROW, OP_COMPARE_CARRY: begin
                // Carry variants only keep Z set, so multi-byte compares chain
                is_sub = 1'b1;
                keep_z = 1'b1;
                sum = {1'b0, a} - {1'b0, b} - {8'h00, cin};
            end
            OP_AND, OP_TEST: begin
                sum = {1'b0, a & (iss.op == OP_TEST ? a : b)};
            end
            OP_OR, OP_SET_BITS: begin
                sum = {1'b0, a | b};
            end
            OP_XOR: begin
                sum = {1'b0, a ^ b};
            end
            OP_CLEAR_BITS: begin
                sum = {1'b0, a & (8'hFF - iss.imm)};
            end
            default: begin
                sum = 9'h000;
            end
        endcase
        r = sum[7:0];
        alu_out.res = {8'h00, r};
        alu_out.flags[`FLAG_Z] = (r == 8'h00) & (~keep_z | flags_in[`FLAG_Z]);
        alu_out.flags[`FLAG_N] = r[7];
        if (is_sub) begin
            alu_out.flags[`FLAG_C] = (~a[7] & b[7]) | (b[7] & r[7]) | (r[7] & ~a[7]);
            alu_out.flags[`FLAG_H] = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
            alu_out.flags[`FLAG_V] = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
        end else begin
            alu_out.flags[`FLAG_C] = sum[8];
            alu_out.flags[`FLAG_H] = (a[3] & b[3]) | (b[3] & ~r[3]) | (~r[3] & a[3]);
            alu_out.flags[`FLAG_V] = (a[7] & b[7] & ~r[7]) | (~a[7] & ~b[7] & r[7]);
        end
        case (iss.op)
            OP_AND, OP_TEST, OP_OR, OP_SET_BITS, OP_XOR, OP_CLEAR_BITS: begin
                alu_out.flags[`FLAG_V] = 1'b0;
            end
            OP_ADD_WORD, OP_SUB_WORD: begin
                if (iss.op == OP_ADD_WORD) begin
                    wsum = {1'b0, iss.rd_val} + {9'h000, iss.imm};
                    alu_out.flags[`FLAG_C] = ~wsum[15] & iss.rd_val[15];
                    alu_out.flags[`FLAG_V] = ~iss.rd_val[15] & wsum[15];
                end else begin
                    wsum = {1'b0, iss.rd_val} - {9'h000, iss.imm};
                    alu_out.flags[`FLAG_C] = wsum[15] & ~iss.rd_val[15];
                    alu_out.flags[`FLAG_V] = iss.rd_val[15] & ~wsum[15];
                end
                alu_out.res = wsum[15:0];
                alu_out.flags[`FLAG_Z] = (wsum[15:0] == 16'h0000);
                alu_out.flags[`FLAG_N] = wsum[15];
                alu_out.flags[`FLAG_S] = wsum[15] ^ alu_out.flags[`FLAG_V];
            end
            OP_MUL, OP_MUL_SIGNED, OP_MUL_MIXED, OP_FRACTIONAL_MULTIPLY, OP_FRACTIONAL_MULTIPLY_SIGNED, OP_FRACTIONAL_MULTIPLY_MIXED: begin
                // First operand is signed in every form except the unsigned pair
                ma = (iss.op == OP_MUL || iss.op == OP_FRACTIONAL_MULTIPLY) ? {8'h00, a} : {{8{a[7]}}, a};
                mb = (iss.op == OP_MUL_SIGNED || iss.op == OP_FRACTIONAL_MULTIPLY_SIGNED) ? {{8{b[7]}}, b} : {8'h00, b};
                alu_out.flags[`FLAG_C] = prod[15];
                if (iss.op == OP_FRACTIONAL_MULTIPLY || iss.op == OP_FRACTIONAL_MULTIPLY_SIGNED || iss.op == OP_FRACTIONAL_MULTIPLY_MIXED) begin
                    alu_out.res = {prod[14:0], 1'b0};
                end else begin
                    alu_out.res = prod;
                end
                alu_out.flags[`FLAG_Z] = (alu_out.res == 16'h0000);
            end
            default: begin
                alu_out.flags[`FLAG_S] = flags_in[`FLAG_S];
            end
        endcase
    end

    assign prod = 16'(ma * mb);

endmodule

// ==== exec_defs.svh ====
`ifndef EXEC_DEFS_SVH
`define EXEC_DEFS_SVH

// ****************************************
// Status flag bit positions
// ****************************************
`define FLAG_C 0
`define FLAG_Z 1
`define FLAG_N 2
`define FLAG_V 3
`define FLAG_S 4
`define FLAG_H 5
`define FLAG_T 6
`define FLAG_I 7

// ****************************************
// Flag groups touched by each class
// ****************************************
`define MASK_ARITH 8'h2F
`define MASK_WORD 8'h1F
`define MASK_LOGIC 8'h0E
`define MASK_MUL 8'h03
`define MASK_NONE 8'h00

// ****************************************
// Reset values and fixed addresses
// ****************************************
`define FLAGS_RESET 8'h00
`define PC_RESET 16'h0000
`define PRODUCT_PAIR_ADDR 5'h00

// ****************************************
// Execution cycle counts
// ****************************************
`define CYC_ONE 3'h1
`define CYC_TWO 3'h2
`define CYC_THREE 3'h3
`define CYC_FOUR 3'h4

`endif

// ==== exec_pkg.sv ====
package exec_pkg;

    // ****************************************
    // Decoded operations
    // ****************************************
    typedef enum logic [5:0] {
        OP_ADD = 6'b000000,
        OP_ADD_CARRY = 6'b000001,
        OP_ADD_WORD = 6'b000010,
        OP_SUB = 6'b000011,
        OP_SUB_BORROW = 6'b000100,
        OP_SUB_WORD = 6'b000101,
        OP_AND = 6'b000110,
        OP_OR = 6'b000111,
        OP_XOR = 6'b001000,
        OP_SET_BITS = 6'b001001,
        OP_CLEAR_BITS = 6'b001010,
        OP_TEST = 6'b001011,
        OP_MUL = 6'b001100,
        OP_MUL_SIGNED = 6'b001101,
        OP_MUL_MIXED = 6'b001110,
        OP_FRACTIONAL_MULTIPLY = 6'b001111,
        OP_FRACTIONAL_MULTIPLY_SIGNED = 6'b010000,
        OP_FRACTIONAL_MULTIPLY_MIXED = 6'b010001,
        OP_JUMP_INDIRECT = 6'b010010,
        OP_CALL_RELATIVE = 6'b010011,
        OP_CALL_INDIRECT = 6'b010100,
        OP_CALL_DIRECT = 6'b010101,
        OP_SKIP_EQUAL = 6'b010110,
        OP_COMPARE = 6'b010111,
        OP_COMPARE_CARRY = 6'b011000,
        OP_SKIP_REG_CLEAR = 6'b011001,
        OP_SKIP_REG_SET = 6'b011010,
        OP_SKIP_IO_CLEAR = 6'b011011,
        OP_SKIP_IO_SET = 6'b011100,
        OP_BRANCH_SET = 6'b011101,
        OP_BRANCH_CLEAR = 6'b011110,
        OP_BRANCH_GE = 6'b011111,
        OP_BRANCH_LT = 6'b100000,
        OP_BRANCH_SH = 6'b100001,
        OP_BRANCH_LO = 6'b100010
    } op_type;

    typedef enum logic {
        PH_READY = 1'b0,
        PH_BUSY = 1'b1
    } phase_type;

    // ****************************************
    // Carriers
    // ****************************************
    typedef struct packed {
        op_type op;
        logic use_imm;
        logic [4:0] rd_addr;
        logic [15:0] rd_val;
        logic [7:0] rr_val;
        logic [7:0] imm;
        logic [11:0] offset;
        logic [2:0] bit_sel;
        logic io_bit;
        logic next_two_words;
        logic [15:0] z_ptr;
        logic [15:0] call_target;
    } issue_type;

    typedef struct packed {
        logic en;
        logic pair;
        logic [4:0] addr;
        logic [15:0] data;
    } wr_type;

    typedef struct packed {
        logic en;
        logic [15:0] addr;
    } push_type;

    typedef struct packed {
        logic [15:0] res;
        logic [7:0] flags;
    } alu_out_type;

    typedef struct packed {
        phase_type phase;
        logic [2:0] busy;
        logic [15:0] pc;
        logic [7:0] flags;
        wr_type wr;
        push_type push;
    } state_type;

endpackage

// ==== tb_top.sv ====
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import exec_pkg::*;

    // ****************************************
    // Bench state
    // ****************************************
    logic core_clk, resetn, issue_valid, issue_ready;
    issue_type issue, iss;
    wr_type wr, w;
    push_type push, p;
    logic [15:0] pc, mpc, step;
    logic [7:0] status_flags;
    int mismatches = 0;
    int checked = 0;

    cpu_alu_branch_exec u_dut (.core_clk(core_clk), .resetn(resetn), .issue_valid(issue_valid), .issue(issue),
        .issue_ready(issue_ready), .wr(wr), .push(push), .pc(pc), .status_flags(status_flags));

    always #10 core_clk = ~core_clk;

    task automatic end_of_test;
        $display("Comparisons %0d, mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input logic ok, input string m);
        checked++;
        if (ok !== 1'b1) begin
            mismatches++;
            $display("MISMATCH at %0t: %s", $time, m);
        end
    endtask

    // ****************************************
    // One instruction: we 0 none, 1 byte, 2 pair, 3 product pair, 4 not checked
    // ****************************************
    task automatic run(input op_type o, input logic [15:0] a, input logic [7:0] b, input logic [2:0] cyc,
        input logic [7:0] ef, input logic [2:0] we, input logic [15:0] er);
        int n;
        iss.op = o;
        iss.rd_val = a;
        // Unused operand gets the inverse so a wrong select shows up
        iss.rr_val = iss.use_imm ? ~b : b;
        iss.imm = iss.use_imm ? b : ~b;
        issue = iss;
        issue_valid = 1'b1;
        @(negedge core_clk);
        issue_valid = 1'b0;
        w = wr;
        p = push;
        n = 1;
        while (issue_ready !== 1'b1) begin
            if (n > 8) begin
                mismatches++;
                end_of_test();
            end
            @(negedge core_clk);
            n++;
        end
        chk(n == cyc, "cycle count");
        chk(pc === mpc + step, "program counter");
        chk(status_flags === ef, "status flags");
        if (we != 3'h4) chk(w.en === (we != 3'h0) && (we == 3'h0 || (w.pair === (we > 3'h1) && w.addr ===
            (we == 3'h3 ? 5'h00 : iss.rd_addr) && (we > 3'h1 ? w.data : {8'h00, w.data[7:0]}) === er)), "write");
        if (o < OP_CALL_RELATIVE || o > OP_CALL_DIRECT) chk(p.en === 1'b0, "stray push");
        mpc = mpc + step;
        step = 16'h0001;
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic arith_ops;
        iss.use_imm = 1'b0;
        run(OP_ADD,16'h000F,8'h01,3'h1,8'h20,3'h1,16'h0010);
        run(OP_SUB,16'h0010,8'h01,3'h1,8'h20,3'h1,16'h000F);
        iss.use_imm = 1'b1;
        run(OP_SUB,16'h0000,8'h01,3'h1,8'h25,3'h1,16'h00FF);
        iss.use_imm = 1'b0;
        run(OP_SUB_BORROW,16'h0000,8'h00,3'h1,8'h25,3'h1,16'h00FF);
        run(OP_ADD_CARRY,16'h0001,8'h01,3'h1,8'h00,3'h1,16'h0003);
        iss.use_imm = 1'b1;
        run(OP_ADD_WORD,16'hFFFF,8'h01,3'h2,8'h03,3'h2,16'h0000);
        run(OP_SUB_WORD,16'h0000,8'h01,3'h2,8'h15,3'h2,16'hFFFF);
        $display("arith_ops done");
    endtask

    task automatic logic_ops;
        iss.use_imm = 1'b0;
        run(OP_AND,16'h00F0,8'h0F,3'h1,8'h13,3'h1,16'h0000);
        run(OP_XOR,16'h00AA,8'hAA,3'h1,8'h13,3'h1,16'h0000);
        iss.use_imm = 1'b1;
        run(OP_OR,16'h0080,8'h01,3'h1,8'h15,3'h1,16'h0081);
        run(OP_SET_BITS,16'h0001,8'h80,3'h1,8'h15,3'h1,16'h0081);
        run(OP_CLEAR_BITS,16'h00FF,8'h0F,3'h1,8'h15,3'h1,16'h00F0);
        run(OP_TEST,16'h0000,8'h5A,3'h1,8'h13,3'h1,16'h0000);
        $display("logic_ops done");
    endtask

    task automatic mul_ops;
        iss.use_imm = 1'b0;
        run(OP_MUL,16'h00FF,8'hFF,3'h2,8'h11,3'h3,16'hFE01);
        run(OP_MUL_SIGNED,16'h00FF,8'hFF,3'h2,8'h10,3'h3,16'h0001);
        run(OP_MUL_MIXED,16'h00FF,8'h02,3'h2,8'h11,3'h3,16'hFFFE);
        run(OP_FRACTIONAL_MULTIPLY,16'h0080,8'h80,3'h2,8'h10,3'h3,16'h8000);
        run(OP_FRACTIONAL_MULTIPLY_SIGNED,16'h00C0,8'h40,3'h2,8'h11,3'h3,16'hE000);
        run(OP_FRACTIONAL_MULTIPLY_MIXED,16'h0040,8'h80,3'h2,8'h10,3'h3,16'h4000);
        run(OP_MUL,16'h0000,8'h55,3'h2,8'h12,3'h3,16'h0000);
        $display("mul_ops done");
    endtask

    task automatic flow_ops;
        iss.z_ptr = 16'h1234;
        step = 16'h1234 - mpc;
        run(OP_JUMP_INDIRECT,16'h0000,8'h00,3'h2,8'h12,3'h0,16'h0000);
        iss.offset = 12'hFFE;
        step = 16'hFFFF;
        run(OP_CALL_RELATIVE,16'h0000,8'h00,3'h3,8'h12,3'h0,16'h0000);
        chk(p.en === 1'b1 && p.addr === 16'h1235, "relative return");
        iss.z_ptr = 16'h2000;
        step = 16'h2000 - mpc;
        run(OP_CALL_INDIRECT,16'h0000,8'h00,3'h3,8'h12,3'h0,16'h0000);
        chk(p.en === 1'b1 && p.addr === 16'h1234, "indirect return");
        iss.call_target = 16'h0400;
        step = 16'h0400 - mpc;
        run(OP_CALL_DIRECT,16'h0000,8'h00,3'h4,8'h12,3'h0,16'h0000);
        chk(p.en === 1'b1 && p.addr === 16'h2002, "direct return");
        $display("flow_ops done");
    endtask

    task automatic skip_ops;
        iss.use_imm = 1'b0;
        step = 16'h0002;
        run(OP_SKIP_EQUAL,16'h0055,8'h55,3'h2,8'h12,3'h0,16'h0000);
        iss.next_two_words = 1'b1;
        step = 16'h0003;
        run(OP_SKIP_EQUAL,16'h0055,8'h55,3'h3,8'h12,3'h0,16'h0000);
        run(OP_SKIP_EQUAL,16'h0055,8'h54,3'h1,8'h12,3'h0,16'h0000);
        iss.bit_sel = 3'h3;
        run(OP_SKIP_REG_CLEAR,16'h0000,8'h08,3'h1,8'h12,3'h0,16'h0000);
        step = 16'h0003;
        run(OP_SKIP_REG_SET,16'h0000,8'h08,3'h3,8'h12,3'h0,16'h0000);
        iss.next_two_words = 1'b0;
        step = 16'h0002;
        run(OP_SKIP_REG_CLEAR,16'h0000,8'hF7,3'h2,8'h12,3'h0,16'h0000);
        iss.io_bit = 1'b0;
        step = 16'h0002;
        run(OP_SKIP_IO_CLEAR,16'h0000,8'h00,3'h2,8'h12,3'h0,16'h0000);
        run(OP_SKIP_IO_SET,16'h0000,8'h00,3'h1,8'h12,3'h0,16'h0000);
        $display("skip_ops done");
    endtask

    task automatic branch_ops;
        iss.offset = 12'h010;
        iss.bit_sel = 3'h4;
        step = 16'h0011;
        run(OP_BRANCH_SET,16'h0000,8'h00,3'h2,8'h12,3'h0,16'h0000);
        iss.bit_sel = 3'h0;
        run(OP_BRANCH_SET,16'h0000,8'h00,3'h1,8'h12,3'h0,16'h0000);
        step = 16'h0011;
        run(OP_BRANCH_CLEAR,16'h0000,8'h00,3'h2,8'h12,3'h0,16'h0000);
        step = 16'h0011;
        run(OP_BRANCH_GE,16'h0000,8'h00,3'h2,8'h12,3'h0,16'h0000);
        run(OP_BRANCH_LT,16'h0000,8'h00,3'h1,8'h12,3'h0,16'h0000);
        step = 16'h0011;
        run(OP_BRANCH_SH,16'h0000,8'h00,3'h2,8'h12,3'h0,16'h0000);
        run(OP_BRANCH_LO,16'h0000,8'h00,3'h1,8'h12,3'h0,16'h0000);
        iss.use_imm = 1'b1;
        run(OP_COMPARE,16'h0003,8'h05,3'h1,8'h35,3'h0,16'h0000);
        iss.offset = 12'hFF0;
        step = 16'hFFF1;
        run(OP_BRANCH_LO,16'h0000,8'h00,3'h2,8'h35,3'h0,16'h0000);
        step = 16'hFFF1;
        run(OP_BRANCH_LT,16'h0000,8'h00,3'h2,8'h35,3'h0,16'h0000);
        run(OP_BRANCH_GE,16'h0000,8'h00,3'h1,8'h35,3'h0,16'h0000);
        run(OP_BRANCH_SH,16'h0000,8'h00,3'h1,8'h35,3'h0,16'h0000);
        iss.use_imm = 1'b0;
        run(OP_COMPARE,16'h0005,8'h05,3'h1,8'h12,3'h0,16'h0000);
        run(OP_COMPARE_CARRY,16'h0005,8'h05,3'h1,8'h12,3'h0,16'h0000);
        run(OP_COMPARE_CARRY,16'h0005,8'h04,3'h1,8'h10,3'h0,16'h0000);
        $display("branch_ops done");
    endtask

    task automatic reset_check;
        resetn = 1'b0;
        @(negedge core_clk);
        chk(pc === 16'h0000 && status_flags === 8'h00 && issue_ready === 1'b1, "reset values");
        resetn = 1'b1;
        mpc = 16'h0000;
        $display("reset_check done");
    endtask

    initial begin
        core_clk = 1'b0;
        resetn = 1'b0;
        issue_valid = 1'b0;
        iss = '0;
        iss.rd_addr = 5'h18;
        issue = iss;
        mpc = 16'h0000;
        step = 16'h0001;
        repeat (2) @(negedge core_clk);
        reset_check();
        arith_ops();
        logic_ops();
        mul_ops();
        flow_ops();
        skip_ops();
        branch_ops();
        reset_check();
        end_of_test();
    end
endmodule
